// file: rtl/nss_map.svh
// Constants of the sentence scheduler: ids, characters, timing.
// Assumes a single core clock; included by the scheduler and its checker.
`ifndef NSS_MAP_SVH
`define NSS_MAP_SVH
`define NSS_CLK_HZ      125000000
`define NSS_TICK_S      1
`define NSS_SEC_CYCLES  (`NSS_CLK_HZ * `NSS_TICK_S)
`define NSS_PER_DIGITS  3'h4
`define NSS_BODY_LEN    6'h21
`define NSS_BAUD_TEXT   14'h12C0
`define NSS_BAUD_BIN    14'h2580
`define NSS_ID_TRACK    24'h56_5447
`define NSS_ID_DATE     24'h5A_4441
`define NSS_ID_FORMAT   24'h46_4F52
`define NSS_CH_DOLLAR   8'h24
`define NSS_CH_STAR     8'h2A
`define NSS_CH_COMMA    8'h2C
`define NSS_CH_DOT      8'h2E
`define NSS_CH_ZERO     8'h30
`define NSS_CH_CR       8'h0D
`define NSS_CH_LF       8'h0A
`define NSS_FIFO_DEPTH  4
`endif

// file: rtl/nss_pkg.sv
// Types shared by the sentence scheduler, its checker and the bench.
// Navigation values arrive as BCD digits from the solution logic.
package nss_pkg;
  typedef struct packed {
    logic        fix;
    logic [15:0] track;
    logic [15:0] knots;
    logic [15:0] kmh;
  } nss_nav_t;
  typedef struct packed {
    logic [31:0] hms;
    logic [7:0]  day;
    logic [7:0]  month;
    logic [15:0] year;
  } nss_utc_t;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_PFX = 3'b001, P_ID = 3'b010, P_ARG = 3'b011,
    P_CKH  = 3'b100, P_CKL = 3'b101, P_CR = 3'b110, P_LF  = 3'b111
  } nss_pst_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_BODY = 3'b001, T_STAR = 3'b010, T_CKH = 3'b011,
    T_CKL  = 3'b100, T_CR   = 3'b101, T_LF   = 3'b110
  } nss_tst_t;
  typedef struct packed {
    logic        cont;
    logic        pend;
    logic [13:0] per;
    logic [13:0] cnt;
  } nss_sched_t;
  typedef struct packed {
    nss_pst_t        p_st;
    logic [2:0]      p_idx;
    logic [7:0]      p_xsum;
    logic [23:0]     id;
    logic [13:0]     arg;
    logic [2:0]      ndig;
    logic            bin;
    logic [13:0]     baud;
    logic [26:0]     sec_cnt;
    nss_sched_t [1:0] sched;
    nss_tst_t        t_st;
    logic            t_sel;
    logic [5:0]      t_idx;
    logic [7:0]      t_xsum;
  } nss_state_t;
endpackage

// file: rtl/nss_fifo.sv
// Small synchronous FIFO, width and depth set by parameters.
// Assumes push and pop on the core clock; depth is a power of two.
`timescale 1ns/10ps
module nss_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } nss_fst_t;
  nss_fst_t s_q;
  nss_fst_t s_d;
  logic     push;
  logic     pop;

  assign o_ready = (s_q.cnt != (AW+1)'(D));
  assign o_valid = (s_q.cnt != '0);
  assign o_data  = s_q.mem[s_q.rp];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: rtl/nss_sched.sv
// Text command handler and sentence scheduler of the primary port.
// Assumes a byte receiver and transmitter on the same clock outside.
// Behaviour
// R01: Four-digit period selects once or repeated output
// R02: Asterisk only precedes checksum; else CR LF
// R03: Poll during continuous output sends once, stops
// R04: No fix nulls all track sentence numbers
// R05: Magnetic track field always empty
// R06: Track sentence fields ordered with T M N K
// R07: Ground speed in knots and km/h
// R08: Date sentence reports UTC, zone 00:00
// R09: Date sentence time, day, month, year, zone order
// R10: Zone hours and minutes within printed ranges
// R11: Format command argument 0 selects binary protocol
// R12: Format switch moves baud 4800 to 9600
// R13: Binary mode ignores all text commands
// R14: No reply to the format command
// R15: Rate command enables sentence and sets rate
// R16: Checksum is XOR between dollar and asterisk
// R17: Period zero polls, nonzero runs continuously
`timescale 1ns/10ps
`include "nss_map.svh"
module nss_sched import nss_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `NSS_SEC_CYCLES,
  parameter int          FIFO_DEPTH = `NSS_FIFO_DEPTH
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire nss_nav_t    i_nav,
  input  wire nss_utc_t    i_utc,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_binary_mode,
  output logic [13:0]      o_baud_rate
);
  nss_state_t s_q;
  nss_state_t s_d;
  logic       push_v;
  logic [7:0] push_b;
  logic       fifo_rdy;
  logic [8:0] gen;

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    hex_val = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46) hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
  endfunction

  function automatic logic [7:0] pfx_chr(input logic [2:0] k);
    case (k)
      3'h0:    pfx_chr = 8'h50;
      3'h1:    pfx_chr = 8'h4D;
      3'h2:    pfx_chr = 8'h4F;
      3'h3:    pfx_chr = 8'h54;
      3'h4:    pfx_chr = 8'h47;
      default: pfx_chr = `NSS_CH_COMMA;
    endcase
  endfunction

  // Digit k (from the left) of a BCD word, as ASCII
  function automatic logic [7:0] dig(input logic [31:0] v,
                                     input int top, input int k);
    dig = {4'h3, v[(top - 4*k) -: 4]};
  endfunction

  // One body character: bit 8 marks a position left out
  function automatic logic [8:0] gen_chr(input logic sel,
                                         input logic [5:0] idx,
                                         input nss_nav_t nav,
                                         input nss_utc_t utc);
    logic [7:0] c;
    logic       skip;
    int         k;
    c    = `NSS_CH_COMMA;
    skip = 1'b0;
    k    = 0;
    case (idx)
      6'h00: c = `NSS_CH_DOLLAR;
      6'h01: c = 8'h47;
      6'h02: c = 8'h50;
      6'h03: c = sel ? 8'h5A : 8'h56;
      6'h04: c = sel ? 8'h44 : 8'h54;
      6'h05: c = sel ? 8'h41 : 8'h47;
      default: begin
        if (!sel) begin
          // R06 field order
          if (idx == 6'h0D) c = 8'h54;
          if (idx == 6'h10) c = 8'h4D;
          if (idx == 6'h18) c = 8'h4E;
          if (idx == 6'h20) c = 8'h4B;
          // Track digits, then R07 knots and km/h
          if (idx >= 6'h07 && idx <= 6'h0B) begin
            k = int'(idx) - 7;
            c = (k == 3) ? `NSS_CH_DOT : dig({16'h0, nav.track}, 15,
                                            (k == 4) ? 3 : k);
          end
          if (idx >= 6'h12 && idx <= 6'h16) begin
            k = int'(idx) - 18;
            c = (k == 3) ? `NSS_CH_DOT : dig({16'h0, nav.knots}, 15,
                                            (k == 4) ? 3 : k);
          end
          if (idx >= 6'h1A && idx <= 6'h1E) begin
            k = int'(idx) - 26;
            c = (k == 3) ? `NSS_CH_DOT : dig({16'h0, nav.kmh}, 15,
                                            (k == 4) ? 3 : k);
          end
          // R04 nulled without fix
          skip = !nav.fix && (c != `NSS_CH_COMMA) && (idx != 6'h0D) &&
                 (idx != 6'h10) && (idx != 6'h18) && (idx != 6'h20);
          // R05 magnetic track empty, only its comma
          if (idx == 6'h0F) c = `NSS_CH_COMMA;
        end else begin
          // R09 time, date, zone order
          if (idx >= 6'h07 && idx <= 6'h0F) begin
            k = int'(idx) - 7;
            c = (k == 6) ? `NSS_CH_DOT :
                dig(utc.hms, 31, (k > 6) ? k - 1 : k);
          end
          if (idx == 6'h11 || idx == 6'h12)
            c = dig({24'h0, utc.day}, 7, int'(idx) - 17);
          if (idx == 6'h14 || idx == 6'h15)
            c = dig({24'h0, utc.month}, 7, int'(idx) - 20);
          if (idx >= 6'h17 && idx <= 6'h1A)
            c = dig({16'h0, utc.year}, 15, int'(idx) - 23);
          // R08 R10 zone fixed at 00:00
          if (idx == 6'h1C || idx == 6'h1D || idx == 6'h1F ||
              idx == 6'h20) c = `NSS_CH_ZERO;
        end
      end
    endcase
    gen_chr = {skip, c};
  endfunction

  assign gen = gen_chr(s_q.t_sel, s_q.t_idx, i_nav, i_utc);

  always_comb begin
    logic [7:0] b;
    logic       rx;
    logic [4:0] hv;
    logic       adv;
    b   = i_rx_data;
    hv  = hex_val(i_rx_data);
    adv = 1'b0;
    s_d = s_q;
    // R13 text ignored in binary mode
    rx  = i_rx_valid && !s_q.bin;

    // One-second tick drives the periodic counters
    s_d.sec_cnt = s_q.sec_cnt + 27'h1;
    if (s_q.sec_cnt == 27'(SEC_CYCLES - 1)) begin
      s_d.sec_cnt = 27'h0;
      for (int i = 0; i < 2; i++) begin
        if (s_q.sched[i].cont) begin
          // R01 repeat at the period
          if (s_q.sched[i].cnt + 14'h1 >= s_q.sched[i].per) begin
            s_d.sched[i].cnt  = 14'h0;
            s_d.sched[i].pend = 1'b1;
          end else begin
            s_d.sched[i].cnt = s_q.sched[i].cnt + 14'h1;
          end
        end
      end
    end

    // Sentence emitter
    push_v = 1'b0;
    push_b = gen[7:0];
    case (s_q.t_st)
      T_IDLE: begin
        if (s_q.sched[0].pend || s_q.sched[1].pend) begin
          s_d.t_sel  = !s_q.sched[0].pend;
          s_d.sched[!s_q.sched[0].pend].pend = 1'b0;
          s_d.t_idx  = 6'h0;
          s_d.t_xsum = 8'h0;
          s_d.t_st   = T_BODY;
        end
      end
      T_BODY: begin
        if (s_q.t_idx == `NSS_BODY_LEN) begin
          s_d.t_st = T_STAR;
        end else if (gen[8]) begin
          s_d.t_idx = s_q.t_idx + 6'h1;
        end else begin
          push_v = 1'b1;
          if (fifo_rdy) begin
            s_d.t_idx = s_q.t_idx + 6'h1;
            // R16 checksum after dollar
            if (s_q.t_idx != 6'h0) s_d.t_xsum = s_q.t_xsum ^ gen[7:0];
          end
        end
      end
      T_STAR: begin
        push_v = 1'b1;
        push_b = `NSS_CH_STAR;
        adv    = 1'b1;
      end
      T_CKH: begin
        push_v = 1'b1;
        push_b = hex_chr(s_q.t_xsum[7:4]);
        adv    = 1'b1;
      end
      T_CKL: begin
        push_v = 1'b1;
        push_b = hex_chr(s_q.t_xsum[3:0]);
        adv    = 1'b1;
      end
      T_CR: begin
        push_v = 1'b1;
        push_b = `NSS_CH_CR;
        adv    = 1'b1;
      end
      T_LF: begin
        push_v = 1'b1;
        push_b = `NSS_CH_LF;
        if (fifo_rdy) s_d.t_st = T_IDLE;
      end
      default: s_d.t_st = T_IDLE;
    endcase
    if (adv && fifo_rdy) s_d.t_st = nss_tst_t'(s_q.t_st + 3'h1);

    // Command parser
    if (rx && b == `NSS_CH_DOLLAR) begin
      s_d.p_st   = P_PFX;
      s_d.p_idx  = 3'h0;
      s_d.p_xsum = 8'h0;
    end else if (rx) begin
      s_d.p_st = P_IDLE;
      case (s_q.p_st)
        P_IDLE: s_d.p_st = P_IDLE;
        P_PFX: begin
          if (b == pfx_chr(s_q.p_idx)) begin
            s_d.p_xsum = s_q.p_xsum ^ b;
            s_d.p_idx  = s_q.p_idx + 3'h1;
            s_d.p_st   = (s_q.p_idx == 3'h5) ? P_ID : P_PFX;
            if (s_q.p_idx == 3'h5) s_d.p_idx = 3'h0;
          end
        end
        P_ID: begin
          s_d.p_xsum = s_q.p_xsum ^ b;
          if (s_q.p_idx < 3'h3) begin
            s_d.id    = {s_q.id[15:0], b};
            s_d.p_idx = s_q.p_idx + 3'h1;
            s_d.p_st  = P_ID;
          end else if (b == `NSS_CH_COMMA) begin
            s_d.arg  = 14'h0;
            s_d.ndig = 3'h0;
            s_d.p_st = P_ARG;
          end
        end
        P_ARG: begin
          if (b >= 8'h30 && b <= 8'h39 && s_q.ndig < `NSS_PER_DIGITS) begin
            s_d.arg    = 14'(s_q.arg * 14'hA + {10'h0, b[3:0]});
            s_d.ndig   = s_q.ndig + 3'h1;
            s_d.p_xsum = s_q.p_xsum ^ b;
            s_d.p_st   = P_ARG;
          // R02 asterisk means checksum
          end else if (b == `NSS_CH_STAR) begin
            s_d.p_st = P_CKH;
          end else if (b == `NSS_CH_CR) begin
            s_d.p_st = P_LF;
          end
        end
        // R16 checksum compared
        P_CKH: if (hv[4] && hv[3:0] == s_q.p_xsum[7:4]) s_d.p_st = P_CKL;
        P_CKL: if (hv[4] && hv[3:0] == s_q.p_xsum[3:0]) s_d.p_st = P_CR;
        P_CR:  if (b == `NSS_CH_CR) s_d.p_st = P_LF;
        P_LF: begin
          if (b == `NSS_CH_LF && s_q.ndig != 3'h0) begin
            if (s_q.id == `NSS_ID_TRACK || s_q.id == `NSS_ID_DATE) begin
              // R15 enable and set rate
              if (s_q.arg == 14'h0) begin
                // R17 R03 poll stops repeats
                s_d.sched[s_q.id == `NSS_ID_DATE].pend = 1'b1;
                s_d.sched[s_q.id == `NSS_ID_DATE].cont = 1'b0;
              end else begin
                s_d.sched[s_q.id == `NSS_ID_DATE].cont = 1'b1;
                s_d.sched[s_q.id == `NSS_ID_DATE].per  = s_q.arg;
                s_d.sched[s_q.id == `NSS_ID_DATE].cnt  = 14'h0;
              end
            end else if (s_q.id == `NSS_ID_FORMAT &&
                         s_q.ndig == 3'h1 && s_q.arg == 14'h0) begin
              // R11 R12 R14 silent switch
              s_d.bin   = 1'b1;
              s_d.baud  = `NSS_BAUD_BIN;
              s_d.sched = '0;
            end
          end
        end
        default: s_d.p_st = P_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q      <= '0;
      s_q.baud <= `NSS_BAUD_TEXT;
    end else begin
      s_q <= s_d;
    end
  end

  nss_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_valid    (push_v),
    .i_data     (push_b),
    .o_ready    (fifo_rdy),
    .o_valid    (o_tx_valid),
    .o_data     (o_tx_data),
    .i_ready    (i_tx_ready)
  );

  assign o_binary_mode = s_q.bin;
  assign o_baud_rate   = s_q.baud;
endmodule

// file: verif/nss_sched_checker.sv
// Port checker of the sentence scheduler.
// Bound to nss_sched; sees its ports only, one clock domain.
`timescale 1ns/10ps
`include "nss_map.svh"
module nss_sched_checker import nss_pkg::*; #(
  parameter int unsigned SEC_CYCLES = 20,
  parameter int          FIFO_DEPTH = 4
) (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_data,
  input wire nss_nav_t    i_nav,
  input wire nss_utc_t    i_utc,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  input wire logic        o_binary_mode,
  input wire logic [13:0] o_baud_rate
);
  logic       pop;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  assign pop = o_tx_valid & i_tx_ready;
  // Last two bytes taken by the transmitter
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p1_q <= `NSS_CH_LF;
      p2_q <= `NSS_CH_CR;
    end else if (pop) begin
      p1_q <= o_tx_data;
      p2_q <= p1_q;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_frame_start: assert property (
    pop && p1_q == `NSS_CH_LF |-> o_tx_data == `NSS_CH_DOLLAR)
    else $error("sentence does not start with dollar");
  a_cr_then_lf: assert property (
    pop && p1_q == `NSS_CH_CR |-> o_tx_data == `NSS_CH_LF)
    else $error("carriage return not followed by line feed");
  a_ck_hex: assert property (
    pop && (p1_q == `NSS_CH_STAR || p2_q == `NSS_CH_STAR)
    |-> o_tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("checksum digit not upper-case hex");
  a_mag_empty: assert property (
    pop && o_tx_data == 8'h4D |-> p1_q == `NSS_CH_COMMA
    && p2_q == `NSS_CH_COMMA)
    else $error("magnetic track field not empty");
  a_nofix_null: assert property (
    pop && !i_nav.fix && o_tx_data inside {8'h4E, 8'h4B}
    |-> p1_q == `NSS_CH_COMMA && p2_q == `NSS_CH_COMMA)
    else $error("speed field not nulled without fix");
  a_hold_data: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("head byte changed while stalled");
  a_baud_match: assert property (
    o_baud_rate == (o_binary_mode ? `NSS_BAUD_BIN : `NSS_BAUD_TEXT))
    else $error("baud rate does not match mode");
  a_bin_sticky: assert property (
    o_binary_mode |=> o_binary_mode)
    else $error("binary mode left without reset");
  a_switch_cause: assert property (
    $rose(o_binary_mode) |-> $past(i_rx_valid)
    && $past(i_rx_data) == `NSS_CH_LF)
    else $error("mode switched without a command end");
  c_sentence: cover property (pop && o_tx_data == `NSS_CH_DOLLAR);
  c_switch: cover property ($rose(o_binary_mode));
  c_stall: cover property (o_tx_valid && !i_tx_ready [*3]);
endmodule
bind nss_sched nss_sched_checker #(
  .SEC_CYCLES(SEC_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
  .i_rx_data(i_rx_data), .i_nav(i_nav), .i_utc(i_utc),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_binary_mode(o_binary_mode), .o_baud_rate(o_baud_rate));

// file: verif/nss_host_model.sv
// Host model: takes transmitted bytes, stalling at random when slow.
// Assumes the core clock; captured text is read by the bench.
`timescale 1ns/10ps
module nss_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  int    seed = 52435;
  string got = "";
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_ready <= 1'b0;
    end else begin
      if (i_tx_valid && o_tx_ready) begin
        got = {got, $sformatf("%c", i_tx_data)};
      end
      o_tx_ready <= i_slow ? ($random(seed) % 2 == 0) : 1'b1;
    end
  end
endmodule

// file: verif/tb_top.sv
// Self-checking bench of the sentence scheduler with a host model.
// Assumes a shortened second (SECC cycles) to keep periods short.
`timescale 1ns/10ps
module tb_top import nss_pkg::*; ;
  localparam int SECC = 100;
  logic        i_core_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        slow = 1'b0;
  nss_nav_t    nav = '0;
  nss_utc_t    utc = '0;
  logic        tx_valid;
  logic        tx_ready;
  logic        bin_mode;
  logic [7:0]  tx_data;
  logic [13:0] baud;
  int          err_count = 0;
  int          tests_run = 0;
  int          seed = 52435;
  int          cyc = 0;
  string       hx = "0123456789ABCDEF";
  string       vcp = string'(40'h50_4D4F_5447);
  string       g;
  always #4 i_core_clk = ~i_core_clk;
  nss_sched #(.SEC_CYCLES(SECC), .FIFO_DEPTH(4)) DUT (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_nav(nav), .i_utc(utc), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_binary_mode(bin_mode),
    .o_baud_rate(baud));
  nss_host_model u_host (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_slow(slow),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));
  function automatic string ck(string s);
    logic [7:0] x;
    x = 8'h00;
    foreach (s[i]) x ^= s[i];
    return $sformatf("%c%c", hx[x[7:4]], hx[x[3:0]]);
  endfunction
  function automatic string cmd(string b, bit c);
    string s;
    s = {vcp, ",", b};
    return c ? {"$", s, "*", ck(s), "\r\n"} : {"$", s, "\r\n"};
  endfunction
  function automatic string frame(string b);
    return {"$", b, "*", ck(b), "\r\n"};
  endfunction
  function automatic string dd(logic [15:0] v);
    return $sformatf("%h%h.%h", v[15:8], v[7:4], v[3:0]);
  endfunction
  function automatic string vtg(nss_nav_t n);
    if (!n.fix) return frame("GPVTG,,T,,M,,N,,K");
    return frame($sformatf("GPVTG,%s,T,,M,%s,N,%s,K",
                           dd(n.track), dd(n.knots), dd(n.kmh)));
  endfunction
  function automatic string zda(nss_utc_t u);
    return frame($sformatf("GPZDA,%h.%h,%h,%h,%h,00,00", u.hms[31:8],
                           u.hms[7:0], u.day, u.month, u.year));
  endfunction
  function automatic logic [15:0] rbcd();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) v[4*i+:4] = 4'($unsigned($random(seed)) % 10);
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic send(string s);
    foreach (s[i]) begin
      @(negedge i_core_clk);
      rx_valid = 1'b1;
      rx_data = s[i];
    end
    @(negedge i_core_clk);
    rx_valid = 1'b0;
  endtask
  task automatic cap(input string c, output string r);
    int idle;
    u_host.got = "";
    send(c);
    idle = 0;
    for (int k = 0; k < 3000 && idle < 80; k++) begin
      @(negedge i_core_clk);
      idle = tx_valid ? 0 : idle + 1;
    end
    r = u_host.got;
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    chk(32'(baud), 32'h0000_12C0);
    utc = '{hms: 32'h2359_5999, day: 8'h31, month: 8'h12, year: rbcd()};
    for (int t = 0; t < 6; t++) begin
      slow = 1'($random(seed) & 1);
      nav = '{fix: 1'b1, track: rbcd(), knots: rbcd(), kmh: rbcd()};
      cap(cmd(t[1] ? "VTG,0" : "VTG,0000", t[0]), g);
      chk(32'(g == vtg(nav)), 32'h1);
    end
    $display("Test track polls done");
    nav.fix = 1'b0;
    cap(cmd("VTG,00", 1), g);
    chk(32'(g == vtg(nav)), 32'h1);
    nav.fix = 1'b1;
    cap(cmd("ZDA,0000", 1), g);
    chk(32'(g == zda(utc)), 32'h1);
    cap({"$", vcp, ",ZDA,0*", ck({vcp, ",ZDA,01"}), "\r\n"}, g);
    chk(32'(g.len()), 32'h0);
    $display("Test polls and checksum done");
    slow = 1'b1;
    u_host.got = "";
    send(cmd("ZDA,0002", 0));
    repeat (1000) @(negedge i_core_clk);
    g = u_host.got;
    chk(32'(g.len() >= 2 * zda(utc).len()), 32'h1);
    chk(32'(g.substr(0, zda(utc).len() - 1) == zda(utc)), 32'h1);
    cap(cmd("ZDA,0", 1), g);
    chk(32'(g.substr(g.len() - zda(utc).len(), g.len() - 1) == zda(utc)),
        32'h1);
    u_host.got = "";
    repeat (700) @(negedge i_core_clk);
    chk(32'(u_host.got.len()), 32'h0);
    $display("Test periodic and stop done");
    cap(cmd("FOR,1", 0), g);
    chk(32'(bin_mode), 32'h0);
    cap(cmd("FOR,0", 1), g);
    chk(32'(g.len()), 32'h0);
    chk(32'(bin_mode), 32'h1);
    chk(32'(baud), 32'h0000_2580);
    cap(cmd("VTG,0000", 0), g);
    chk(32'(g.len()), 32'h0);
    $display("Test format switch done");
    results();
  end
endmodule
